// file: rtl/txsh_pkg.sv
package txsh_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] TXSH_OFF_PDAL  = 8'h00;
  localparam logic [7:0] TXSH_OFF_PDAH  = 8'h04;
  localparam logic [7:0] TXSH_OFF_PBC   = 8'h08;
  localparam logic [7:0] TXSH_OFF_PST   = 8'h0c;
  localparam logic [7:0] TXSH_OFF_NBAL  = 8'h10;
  localparam logic [7:0] TXSH_OFF_STYLE = 8'h14;
  localparam logic [7:0] TXSH_OFF_CTRL  = 8'h18;

  // ---------------------------------------------------------------
  // Register indexes after decode
  // ---------------------------------------------------------------
  localparam logic [2:0] TXSH_IDX_PDAL  = 3'h0;
  localparam logic [2:0] TXSH_IDX_PDAH  = 3'h1;
  localparam logic [2:0] TXSH_IDX_PBC   = 3'h2;
  localparam logic [2:0] TXSH_IDX_PST   = 3'h3;
  localparam logic [2:0] TXSH_IDX_NBAL  = 3'h4;
  localparam logic [2:0] TXSH_IDX_STYLE = 3'h5;
  localparam logic [2:0] TXSH_IDX_CTRL  = 3'h6;
  localparam logic [2:0] TXSH_IDX_NONE  = 3'h7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         TXSH_POS_WIDE    = 8;
  localparam int         TXSH_POS_STOP    = 0;
  localparam int         TXSH_POS_SUSPEND = 1;
  localparam int         TXSH_POS_OPEN    = 2;
  localparam logic [7:0] TXSH_RST_STYLE   = 8'h00;
  localparam logic       TXSH_RST_STOP    = 1'b1;
  localparam logic       TXSH_RST_SUSPEND = 1'b0;

  // ---------------------------------------------------------------
  // Style codes and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] TXSH_STYLE_NARROW = 8'h00;
  localparam logic [7:0] TXSH_STYLE_RSVD1  = 8'h01;
  localparam logic [7:0] TXSH_STYLE_WIDE   = 8'h02;
  localparam logic [7:0] TXSH_STYLE_BURST  = 8'h03;
  localparam logic [1:0] TXSH_RESP_OKAY    = 2'h0;
  localparam logic [1:0] TXSH_RESP_SLVERR  = 2'h2;
  localparam logic [1:0] TXSH_RESP_DECERR  = 2'h3;

endpackage

// file: rtl/txsh_style_if.sv
`timescale 1ns/1ns
// Style code out to the decoder, decoded layout back
interface txsh_style_if;
  logic [7:0] code;
  logic       wide;
  logic       init_burst;
  logic       ring_burst;
  logic       reserved;
  modport dec  (input code, output wide, init_burst, ring_burst, reserved);
  modport user (output code, input wide, init_burst, ring_burst, reserved);
endinterface

// file: rtl/txsh_style_dec.sv
`timescale 1ns/1ns
module txsh_style_dec
(
  input  wire logic aclk,
  input  wire logic aresetn,
  txsh_style_if.dec sty
);

  // Decode of the structure style code
  always_comb
  begin
    sty.wide       = 1'b0;
    sty.init_burst = 1'b0;
    sty.ring_burst = 1'b0;
    sty.reserved   = 1'b0;
    case (sty.code)
      txsh_pkg::TXSH_STYLE_NARROW:
      begin
        sty.init_burst = 1'b1;
      end
      txsh_pkg::TXSH_STYLE_RSVD1:
      begin
        sty.wide     = 1'b1;
        sty.reserved = 1'b1;
      end
      txsh_pkg::TXSH_STYLE_WIDE:
      begin
        sty.wide       = 1'b1;
        sty.init_burst = 1'b1;
      end
      txsh_pkg::TXSH_STYLE_BURST:
      begin
        sty.wide       = 1'b1;
        sty.init_burst = 1'b1;
        sty.ring_burst = 1'b1;
      end
      default:
      begin
        sty.reserved = 1'b1;
      end
    endcase
  end

  // Checks of the decode
  narrow_style_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sty.code == 8'h00 |-> !sty.wide && sty.init_burst && !sty.ring_burst)
    else $error("style zero decoded wrongly");
  wide_style_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sty.code == 8'h02 |-> sty.wide && sty.init_burst && !sty.ring_burst)
    else $error("style two decoded wrongly");
  burst_style_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sty.code == 8'h03 |-> sty.wide && sty.ring_burst && !sty.reserved)
    else $error("style three decoded wrongly");

endmodule // txsh_style_dec

// file: rtl/txsh_regs.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module txsh_regs
#(
  parameter int AW = 8
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          eng_advance,
  input  wire logic [31:0]   eng_desc_addr,
  input  wire logic [31:0]   eng_tx_desc_word1,
  input  wire logic [15:0]   eng_next_buf_addr_lo,
  output logic               stop_flag,
  output logic               suspend_flag,
  output logic [7:0]         structure_style_code,
  output logic               wide_structure_flag,
  output logic               init_burst_ok,
  output logic               ring_burst_ok,
  output logic               style_reserved
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [AW-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    case (b)
      txsh_pkg::TXSH_OFF_PDAL:  reg_index = txsh_pkg::TXSH_IDX_PDAL;
      txsh_pkg::TXSH_OFF_PDAH:  reg_index = txsh_pkg::TXSH_IDX_PDAH;
      txsh_pkg::TXSH_OFF_PBC:   reg_index = txsh_pkg::TXSH_IDX_PBC;
      txsh_pkg::TXSH_OFF_PST:   reg_index = txsh_pkg::TXSH_IDX_PST;
      txsh_pkg::TXSH_OFF_NBAL:  reg_index = txsh_pkg::TXSH_IDX_NBAL;
      txsh_pkg::TXSH_OFF_STYLE: reg_index = txsh_pkg::TXSH_IDX_STYLE;
      txsh_pkg::TXSH_OFF_CTRL:  reg_index = txsh_pkg::TXSH_IDX_CTRL;
      default:                  reg_index = txsh_pkg::TXSH_IDX_NONE;
    endcase
  endfunction

  // Gated registers need stop or suspend, control is always open
  function automatic logic [1:0] answer(input logic [2:0] idx,
                                        input logic       open);
    if (idx == txsh_pkg::TXSH_IDX_NONE)
      answer = txsh_pkg::TXSH_RESP_DECERR;
    else if (idx != txsh_pkg::TXSH_IDX_CTRL && !open)
      answer = txsh_pkg::TXSH_RESP_SLVERR;
    else
      answer = txsh_pkg::TXSH_RESP_OKAY;
  endfunction

  // Byte-lane merge on the low sixteen bits
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic          aw_held;
  logic [AW-1:0] aw_addr;
  logic          w_held;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          access_open;
  logic          do_write;
  logic [2:0]    wr_idx;
  logic          wr_ok;
  logic [2:0]    rd_idx;
  logic [31:0]   next_rdata;
  logic [15:0]   prev_desc_addr_lo;
  logic [15:0]   prev_desc_addr_hi;
  logic [11:0]   prev_byte_count;
  logic [15:0]   prev_status_copy;
  logic [15:0]   next_buf_addr_lo;

  txsh_style_if sty ();

  assign access_open   = stop_flag | suspend_flag;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx        = reg_index(aw_addr);
  assign wr_ok         = do_write &&
                         answer(wr_idx, access_open) == 2'h0;
  assign rd_idx        = reg_index(s_axi_araddr);
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // ---------------------------------------------------------------
  // Write channel capture
  // ---------------------------------------------------------------
  // Address held until the write completes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_held <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      aw_held <= 1'b1;
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_addr <= s_axi_awaddr;
  end

  // Data held until the write completes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_held <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      w_held <= 1'b1;
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // Write response, held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= txsh_pkg::TXSH_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= answer(wr_idx, access_open);
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Control and style registers
  // ---------------------------------------------------------------
  // Stop and suspend flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stop_flag    <= txsh_pkg::TXSH_RST_STOP;
      suspend_flag <= txsh_pkg::TXSH_RST_SUSPEND;
    end
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_CTRL && w_strb[0])
    begin
      stop_flag    <= w_data[txsh_pkg::TXSH_POS_STOP];
      suspend_flag <= w_data[txsh_pkg::TXSH_POS_SUSPEND];
    end
  end

  // Style code, cleared only by hard reset; wide flag not writable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      structure_style_code <= txsh_pkg::TXSH_RST_STYLE;
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_STYLE && w_strb[0])
      structure_style_code <= w_data[7:0];
  end

  assign sty.code            = structure_style_code;
  assign wide_structure_flag = sty.wide;
  assign init_burst_ok       = sty.init_burst;
  assign ring_burst_ok       = sty.ring_burst;
  assign style_reserved      = sty.reserved;

  txsh_style_dec u_dec
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sty     (sty)
  );

  // ---------------------------------------------------------------
  // Shadow registers: no reset term at all
  // ---------------------------------------------------------------
  // Previous descriptor address, engine advance beats host write
  always_ff @(posedge aclk)
  begin
    if (eng_advance)
    begin
      prev_desc_addr_lo <= eng_desc_addr[15:0];
      prev_desc_addr_hi <= eng_desc_addr[31:16];
    end
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_PDAL)
      prev_desc_addr_lo <= merge16(prev_desc_addr_lo, w_data, w_strb);
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_PDAH)
      prev_desc_addr_hi <= merge16(prev_desc_addr_hi, w_data, w_strb);
  end

  // Previous count and status copies
  always_ff @(posedge aclk)
  begin
    if (eng_advance)
    begin
      prev_byte_count  <= eng_tx_desc_word1[11:0];
      prev_status_copy <= eng_tx_desc_word1[31:16];
    end
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_PBC)
      prev_byte_count <= 12'(merge16({4'h0, prev_byte_count},
                                     w_data, w_strb));
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_PST)
      prev_status_copy <= merge16(prev_status_copy, w_data, w_strb);
  end

  // Next buffer address
  always_ff @(posedge aclk)
  begin
    if (eng_advance)
      next_buf_addr_lo <= eng_next_buf_addr_lo;
    else if (wr_ok && wr_idx == txsh_pkg::TXSH_IDX_NBAL)
      next_buf_addr_lo <= merge16(next_buf_addr_lo, w_data, w_strb);
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  // Read mux, upper half always zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (rd_idx)
      txsh_pkg::TXSH_IDX_PDAL:  next_rdata[15:0] = prev_desc_addr_lo;
      txsh_pkg::TXSH_IDX_PDAH:  next_rdata[15:0] = prev_desc_addr_hi;
      txsh_pkg::TXSH_IDX_PBC:   next_rdata[11:0] = prev_byte_count;
      txsh_pkg::TXSH_IDX_PST:   next_rdata[15:0] = prev_status_copy;
      txsh_pkg::TXSH_IDX_NBAL:  next_rdata[15:0] = next_buf_addr_lo;
      txsh_pkg::TXSH_IDX_STYLE:
      begin
        next_rdata[7:0]                    = structure_style_code;
        next_rdata[txsh_pkg::TXSH_POS_WIDE] = sty.wide;
      end
      txsh_pkg::TXSH_IDX_CTRL:
      begin
        next_rdata[txsh_pkg::TXSH_POS_STOP]    = stop_flag;
        next_rdata[txsh_pkg::TXSH_POS_SUSPEND] = suspend_flag;
        next_rdata[txsh_pkg::TXSH_POS_OPEN]    = access_open;
      end
      default:                  next_rdata = 32'h0000_0000;
    endcase
    if (answer(rd_idx, access_open) != txsh_pkg::TXSH_RESP_OKAY)
      next_rdata = 32'h0000_0000;
  end

  // Read data and response, held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= txsh_pkg::TXSH_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= answer(rd_idx, access_open);
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence closed_shadow_write;
    wr_idx == 3'h0 && do_write && !access_open && !eng_advance;
  endsequence

  sequence both_halves_held;
    aw_held && w_held && !s_axi_bvalid;
  endsequence

  closed_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    closed_shadow_write |=> $stable(prev_desc_addr_lo)
      && s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("shadow write taken while running");
  closed_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && !access_open && rd_idx != 3'h6
      && rd_idx != 3'h7 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("read answered while running");
  addr_capture_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eng_advance |=> {prev_desc_addr_hi, prev_desc_addr_lo}
      == $past(eng_desc_addr))
    else $error("previous address not captured");
  count_copy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eng_advance |=> prev_byte_count == $past(eng_tx_desc_word1[11:0]))
    else $error("byte count not copied");
  status_copy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eng_advance |=> prev_status_copy == $past(eng_tx_desc_word1[31:16]))
    else $error("status not copied");
  next_buf_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eng_advance |=> next_buf_addr_lo == $past(eng_next_buf_addr_lo))
    else $error("next buffer address not captured");
  upper_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("reserved bits not zero");
  keep_prev_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !eng_advance && !do_write |=> $stable(prev_status_copy)
      && $stable(prev_byte_count))
    else $error("previous copy lost");
  wide_follow_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wide_structure_flag == (structure_style_code inside {8'h01, 8'h02,
      8'h03}))
    else $error("wide flag does not follow style");
  style_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> structure_style_code == 8'h00 && !wide_structure_flag)
    else $error("style not cleared by reset");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    both_halves_held |=> s_axi_bvalid && !aw_held && !w_held)
    else $error("write response missing");

endmodule // txsh_regs

// file: tb/tx_descriptor_shadow_regs_test.sv
`timescale 1ns/1ns
module tx_descriptor_shadow_regs_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        adv, stop_f, susp_f, wide, ib, rb, rsv;
  logic [31:0] e_addr, e_word1;
  logic [15:0] e_next;
  logic [7:0]  code;
  logic [7:0]  offs [5];
  int          errors, checks, cycles;

  txsh_regs u_txsh_regs (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eng_advance(adv),
    .eng_desc_addr(e_addr), .eng_tx_desc_word1(e_word1),
    .eng_next_buf_addr_lo(e_next), .stop_flag(stop_f),
    .suspend_flag(susp_f), .structure_style_code(code),
    .wide_structure_flag(wide), .init_burst_ok(ib), .ring_burst_ok(rb),
    .style_reserved(rsv));

  // ------------------------------------------------------------
  // Clock, timeout and common tasks
  // ------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Cut a hang short
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Write with both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aok, wok, ah, wh, bh;
    aok = 1'b0;
    wok = 1'b0;
    bh  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid & aok & wok;
      @(posedge aclk);
      if (ah)
      begin
        awvalid <= 1'b0;
        aok = 1'b1;
      end
      if (wh)
      begin
        wvalid <= 1'b0;
        wok = 1'b1;
      end
    end
    bready <= 1'b0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic aok, ah, rh;
    aok = 1'b0;
    rh  = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid & aok;
      @(posedge aclk);
      if (ah)
      begin
        arvalid <= 1'b0;
        aok = 1'b1;
      end
    end
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // One engine step with given descriptor contents
  task automatic step(input logic [31:0] a, input logic [31:0] w,
                      input logic [15:0] n);
    @(posedge aclk);
    adv     <= 1'b1;
    e_addr  <= a;
    e_word1 <= w;
    e_next  <= n;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals();
    @(negedge aclk);
    chk({stop_f, susp_f}, 2'b10);
    chk(code, txsh_pkg::TXSH_RST_STYLE);
    chk({wide, ib, rb, rsv}, 4'b0100);
    rd(txsh_pkg::TXSH_OFF_CTRL, 32'h5, 2'h0);
  endtask

  // Host fields: upper half zero, byte count twelve bits
  task automatic t_host_rw();
    logic [31:0] d;
    for (int i = 0; i < 5; i++)
    begin
      d = 32'h0000_f1e2 - i * 32'h111;
      wr(offs[i], d, txsh_pkg::TXSH_RESP_OKAY);
    end
    for (int i = 0; i < 5; i++)
    begin
      d = 32'h0000_f1e2 - i * 32'h111;
      if (i == 2)
        d = d & 32'h0000_0fff;
      rd(offs[i], d, 2'h0);
    end
  endtask

  // Style codes 00 to 04 and ff, with the read-only size bit written as one
  task automatic t_styles();
    logic [7:0]  sc [6];
    logic [3:0]  ex [6];
    logic [31:0] d;
    sc = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff};
    ex = '{4'b0100, 4'b1001, 4'b1100, 4'b1110, 4'b0001, 4'b0001};
    for (int i = 0; i < 6; i++)
    begin
      wr(txsh_pkg::TXSH_OFF_STYLE, {23'h0, 1'b1, sc[i]}, 2'h0);
      @(negedge aclk);
      chk({wide, ib, rb, rsv}, ex[i]);
      d = {23'h0, ex[i][3], sc[i]};
      rd(txsh_pkg::TXSH_OFF_STYLE, d, 2'h0);
    end
  endtask

  // Refused while running, open again under suspend, engine steps
  task automatic t_gate_engine();
    wr(txsh_pkg::TXSH_OFF_CTRL, 32'h0, 2'h0);
    wr(offs[0], 32'h0000_7777, txsh_pkg::TXSH_RESP_SLVERR);
    wr(txsh_pkg::TXSH_OFF_STYLE, 32'h2, 2'h2);
    rd(offs[1], 32'h0, txsh_pkg::TXSH_RESP_SLVERR);
    wr(txsh_pkg::TXSH_OFF_CTRL, 32'h2, 2'h0);
    rd(txsh_pkg::TXSH_OFF_CTRL, 32'h6, 2'h0);
    rd(offs[0], 32'h0000_f1e2, 2'h0);
    rd(txsh_pkg::TXSH_OFF_STYLE, 32'h0ff, 2'h0);
    step(32'h8765_4321, 32'hbeef_0abc, 16'h5a5a);
    step(32'h0102_0304, 32'hc001_fedc, 16'h0f0f);
    @(posedge aclk);
    adv <= 1'b0;
    rd(offs[0], 32'h0000_0304, 2'h0);
    rd(offs[1], 32'h0000_0102, 2'h0);
    rd(offs[2], 32'h0000_0edc, 2'h0);
    rd(offs[3], 32'h0000_c001, 2'h0);
    rd(offs[4], 32'h0000_0f0f, 2'h0);
  endtask

  // Shadows survive reset and stop, style returns to zero
  task automatic t_keep();
    wr(txsh_pkg::TXSH_OFF_STYLE, 32'h3, 2'h0);
    wr(txsh_pkg::TXSH_OFF_CTRL, 32'h1, 2'h0);
    rd(offs[3], 32'h0000_c001, 2'h0);
    do_reset();
    rd(offs[0], 32'h0000_0304, 2'h0);
    rd(offs[2], 32'h0000_0edc, 2'h0);
    rd(offs[4], 32'h0000_0f0f, 2'h0);
    rd(txsh_pkg::TXSH_OFF_STYLE, 32'h0, 2'h0);
    wr(8'h1c, 32'h0, txsh_pkg::TXSH_RESP_DECERR);
    rd(8'h1c, 32'h0, txsh_pkg::TXSH_RESP_DECERR);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    offs = '{txsh_pkg::TXSH_OFF_PDAL, txsh_pkg::TXSH_OFF_PDAH,
             txsh_pkg::TXSH_OFF_PBC, txsh_pkg::TXSH_OFF_PST,
             txsh_pkg::TXSH_OFF_NBAL};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, adv} = 7'h0;
    {awaddr, araddr, wstrb} = 20'h0;
    {wdata, e_addr, e_word1, e_next} = 112'h0;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_host_rw();
    t_styles();
    t_gate_engine();
    t_keep();
    close_out();
  end
endmodule // tx_descriptor_shadow_regs_test
